// [resi_status_irq.sv]
// Event status flags, interrupt mask and entry validity of the calendar clock
//
// Strobed register access was decided locally.
`timescale 1ns/100ps

// Operation
// - Alarm flag sets when current time and date meet enabled alarm fields.
// - One-second tick flag sets on every tick and stays set until cleared.
// - Clock event flag sets on the selected time event, held until cleared.
// - Control selector picks minute, hour, noon or midnight as time event.
// - Date period flag sets on the selected calendar event, held until cleared.
// - Control selector picks week, month or year rollover as calendar event.
// - Corruption flag sets on invalid or non-BCD counters, stays while invalid.
// - Corruption flag reads zero only after counters stayed valid since clearing.
// - Writing one to a clear command bit clears its flag; zero does nothing.
// - Writing one to an enable bit enables that interrupt source.
// - Writing one to a disable bit disables that interrupt source.
// - Mask view reads one for enabled sources, zero for disabled ones.
// - Validity bits 0 and 1 flag invalid clock and date entries.
// - Validity bits 2 and 3 flag invalid alarm entries until reprogrammed.
// - Grant flag sets while counters are stopped for software update.
// - Each alarm field takes part in matching only when enabled.
module resi_status_irq (
   input wire logic clk, // 25 MHz clock
   input wire logic rstn, // Asynchronous reset, active low
   input wire logic ce, // Clock enable, freezes all state
   input wire logic [31:0] addr, // Register byte address
   input wire logic [31:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [31:0] rdata, // Read data, cycle after rd
   input wire logic [31:0] cur_clock, // Running clock counters
   input wire logic [31:0] cur_date, // Running date counters
   input wire logic mode_12h, // Counters run in 12-hour mode
   input wire logic updating, // Counters stopped for update
   input wire logic tick_1hz, // One-second pulse
   input wire logic minute_roll, // Minute change pulse
   input wire logic hour_roll, // Hour change pulse
   input wire logic noon_evt, // Noon pulse
   input wire logic midnight_evt, // Day change pulse
   input wire logic week_roll, // Week change pulse
   input wire logic month_roll, // Month change pulse
   input wire logic year_roll, // Year change pulse
   output logic irq // Level interrupt request
);

   localparam int N = resi_pkg::NUM_SRC;

   // ************************************************
   // Range checks
   // ************************************************

   // Packed BCD compares in order once both digits are legal
   function automatic logic bcd_rng(input logic [7:0] v, input logic [7:0] lo,
                                    input logic [7:0] hi);
      logic dig;
      dig = (v[3:0] <= resi_pkg::BCD_DIGIT_MAX) && (v[7:4] <= resi_pkg::BCD_DIGIT_MAX);
      return dig && (v >= lo) && (v <= hi);
   endfunction

   // Hour range depends on the 12/24 mode
   function automatic logic hour_ok(input logic [31:0] w, input logic m12);
      logic [7:0] h;
      h = {2'h0, w[resi_pkg::F_HOUR +: 6]};
      if (m12) begin
         return bcd_rng(h, resi_pkg::BCD_ONE, resi_pkg::BCD_MAX_H12);
      end
      return bcd_rng(h, resi_pkg::BCD_ZERO, resi_pkg::BCD_MAX_H24) && !w[resi_pkg::F_AMPM];
   endfunction

   // Second, minute and hour of a clock or alarm word
   function automatic logic clock_ok(input logic [31:0] w, input logic m12);
      logic s;
      logic m;
      s = bcd_rng({1'b0, w[resi_pkg::F_SEC +: 7]}, resi_pkg::BCD_ZERO, resi_pkg::BCD_MAX_MS);
      m = bcd_rng({1'b0, w[resi_pkg::F_MIN +: 7]}, resi_pkg::BCD_ZERO, resi_pkg::BCD_MAX_MS);
      return s && m && hour_ok(w, m12);
   endfunction

   // Month and date of a date or alarm word
   function automatic logic md_ok(input logic [31:0] w);
      logic mo;
      logic dt;
      mo = bcd_rng({3'h0, w[resi_pkg::F_MONTH +: 5]}, resi_pkg::BCD_ONE, resi_pkg::BCD_MAX_MONTH);
      dt = bcd_rng({2'h0, w[resi_pkg::F_DATE +: 6]}, resi_pkg::BCD_ONE, resi_pkg::BCD_MAX_DATE);
      return mo && dt;
   endfunction

   // Full date word: century, year, weekday, month, date
   function automatic logic date_ok(input logic [31:0] w);
      logic c;
      logic y;
      logic d;
      c = bcd_rng({1'b0, w[resi_pkg::F_CENT +: 7]}, resi_pkg::BCD_MIN_CENT, resi_pkg::BCD_MAX_CENT);
      y = bcd_rng(w[resi_pkg::F_YEAR +: 8], resi_pkg::BCD_ZERO, resi_pkg::BCD_MAX_YEAR);
      d = bcd_rng({5'h0, w[resi_pkg::F_DAY +: 3]}, resi_pkg::BCD_ONE, resi_pkg::BCD_MAX_DAY);
      return c && y && d && md_ok(w);
   endfunction

   // ************************************************
   // Register state
   // ************************************************
   logic [N-1:0] stat_q;
   logic [N-1:0] mask_q;
   logic [3:0] bad_q;
   logic [1:0] clk_sel_q;
   logic [1:0] date_sel_q;
   logic [31:0] clock_alarm_q;
   logic [31:0] date_alarm_q;
   logic match_prev_q;
   logic [N-1:0] set_v;
   logic [N-1:0] clr_v;
   logic match_now;
   logic counters_bad;
   logic clock_sel_evt;
   logic date_sel_evt;

   // Write decodes
   logic wr_ctl;
   logic wr_clock;
   logic wr_date;
   logic wr_clk_alm;
   logic wr_date_alm;
   logic wr_clr;
   logic wr_ien;
   logic wr_idis;
   assign wr_ctl = wr && (addr == resi_pkg::ADR_CONTROL_WORD);
   assign wr_clock = wr && (addr == resi_pkg::ADR_CLOCK_ENTRY);
   assign wr_date = wr && (addr == resi_pkg::ADR_DATE_ENTRY);
   assign wr_clk_alm = wr && (addr == resi_pkg::ADR_CLOCK_ALARM);
   assign wr_date_alm = wr && (addr == resi_pkg::ADR_DATE_ALARM);
   assign wr_clr = wr && (addr == resi_pkg::ADR_STATUS_CLEAR_COMMAND);
   assign wr_ien = wr && (addr == resi_pkg::ADR_IRQ_ENABLE_SET);
   assign wr_idis = wr && (addr == resi_pkg::ADR_IRQ_ENABLE_CLEAR);

   // ************************************************
   // Event sources
   // ************************************************

   // Time event mux; all four codes are legal
   always_comb begin
      unique case (clk_sel_q)
         resi_pkg::SEL_MINUTE: clock_sel_evt = minute_roll;
         resi_pkg::SEL_HOUR: clock_sel_evt = hour_roll;
         resi_pkg::SEL_MIDNIGHT: clock_sel_evt = midnight_evt;
         resi_pkg::SEL_NOON: clock_sel_evt = noon_evt;
      endcase
   end

   // Calendar event mux; the fourth code selects nothing
   always_comb begin
      unique case (date_sel_q)
         resi_pkg::SEL_WEEK: date_sel_evt = week_roll;
         resi_pkg::SEL_MONTH: date_sel_evt = month_roll;
         resi_pkg::SEL_YEAR: date_sel_evt = year_roll;
         default: date_sel_evt = 1'b0;
      endcase
   end

   // Alarm compare; no enabled field means no alarm at all
   always_comb begin
      logic any_en;
      logic hit;
      any_en = 1'b0;
      hit = 1'b1;
      if (clock_alarm_q[resi_pkg::E_SEC]) begin
         any_en = 1'b1;
         hit = hit && (clock_alarm_q[resi_pkg::F_SEC +: 7] == cur_clock[resi_pkg::F_SEC +: 7]);
      end
      if (clock_alarm_q[resi_pkg::E_MIN]) begin
         any_en = 1'b1;
         hit = hit && (clock_alarm_q[resi_pkg::F_MIN +: 7] == cur_clock[resi_pkg::F_MIN +: 7]);
      end
      if (clock_alarm_q[resi_pkg::E_HOUR]) begin
         any_en = 1'b1;
         hit = hit && (clock_alarm_q[resi_pkg::F_HOUR +: 7] == cur_clock[resi_pkg::F_HOUR +: 7]);
      end
      if (date_alarm_q[resi_pkg::E_MONTH]) begin
         any_en = 1'b1;
         hit = hit && (date_alarm_q[resi_pkg::F_MONTH +: 5] == cur_date[resi_pkg::F_MONTH +: 5]);
      end
      if (date_alarm_q[resi_pkg::E_DATE]) begin
         any_en = 1'b1;
         hit = hit && (date_alarm_q[resi_pkg::F_DATE +: 6] == cur_date[resi_pkg::F_DATE +: 6]);
      end
      match_now = any_en && hit;
   end

   // Running counters checked every cycle
   assign counters_bad = !clock_ok(cur_clock, mode_12h) || !date_ok(cur_date);

   // Set and clear vectors; flag sets only on the rising edge of a match,
   // so a clear during the matching second is not undone at once
   always_comb begin
      set_v = '0;
      set_v[resi_pkg::B_GRANT] = updating;
      set_v[resi_pkg::B_MATCH] = match_now && !match_prev_q;
      set_v[resi_pkg::B_TICK] = tick_1hz;
      set_v[resi_pkg::B_CLOCK_EV] = clock_sel_evt;
      set_v[resi_pkg::B_DATE_EV] = date_sel_evt;
      set_v[resi_pkg::B_CORRUPT] = counters_bad;
      clr_v = wr_clr ? wdata[N-1:0] : '0;
   end

   // ************************************************
   // Status flags
   // ************************************************

   // Set wins over clear; corruption and grant re-set while their cause stays
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stat_q <= '0;
         match_prev_q <= 1'b0;
      end else if (ce) begin
         stat_q <= (stat_q & ~clr_v) | set_v;
         match_prev_q <= match_now;
      end
   end

   // ************************************************
   // Interrupt mask and output
   // ************************************************

   // One strobe per cycle, so enable and disable never meet
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mask_q <= '0;
      end else if (ce) begin
         if (wr_ien) begin
            mask_q <= mask_q | wdata[N-1:0];
         end else if (wr_idis) begin
            mask_q <= mask_q & ~wdata[N-1:0];
         end
      end
   end

   // Registered level request, one cycle behind the flags
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(stat_q & mask_q);
      end
   end

   // ************************************************
   // Control, alarm and validity registers
   // ************************************************

   // Selectors and alarm words
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clk_sel_q <= resi_pkg::SEL_MINUTE;
         date_sel_q <= resi_pkg::SEL_WEEK;
         clock_alarm_q <= resi_pkg::RST_WORD;
         date_alarm_q <= resi_pkg::RST_WORD;
      end else if (ce) begin
         if (wr_ctl) begin
            clk_sel_q <= wdata[resi_pkg::F_CLK_SEL +: 2];
            date_sel_q <= wdata[resi_pkg::F_DATE_SEL +: 2];
         end
         if (wr_clk_alm) begin
            clock_alarm_q <= wdata;
         end
         if (wr_date_alm) begin
            date_alarm_q <= wdata;
         end
      end
   end

   // Each bit judged afresh on every write of its register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bad_q <= '0;
      end else if (ce) begin
         if (wr_clock) begin
            bad_q[resi_pkg::B_BAD_CLOCK] <= !clock_ok(wdata, mode_12h);
         end
         if (wr_date) begin
            bad_q[resi_pkg::B_BAD_DATE] <= !date_ok(wdata);
         end
         if (wr_clk_alm) begin
            bad_q[resi_pkg::B_BAD_CLOCK_ALM] <= !clock_ok(wdata, mode_12h);
         end
         if (wr_date_alm) begin
            bad_q[resi_pkg::B_BAD_DATE_ALM] <= !md_ok(wdata);
         end
      end
   end

   // ************************************************
   // Read port
   // ************************************************

   // Data stand for one cycle only; write-only and unmapped read zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= resi_pkg::RST_WORD;
      end else if (ce) begin
         rdata <= resi_pkg::RST_WORD;
         if (rd) begin
            unique case (addr)
               resi_pkg::ADR_CONTROL_WORD: begin
                  rdata[resi_pkg::F_CLK_SEL +: 2] <= clk_sel_q;
                  rdata[resi_pkg::F_DATE_SEL +: 2] <= date_sel_q;
               end
               resi_pkg::ADR_CLOCK_ALARM: rdata <= clock_alarm_q;
               resi_pkg::ADR_DATE_ALARM: rdata <= date_alarm_q;
               resi_pkg::ADR_EVENT_STATUS: rdata[N-1:0] <= stat_q;
               resi_pkg::ADR_IRQ_MASK_VIEW: rdata[N-1:0] <= mask_q;
               resi_pkg::ADR_ENTRY_VALIDITY: rdata[3:0] <= bad_q;
               default: rdata <= resi_pkg::RST_WORD;
            endcase
         end
      end
   end

   // ************************************************
   // Checks
   // ************************************************

   tick_sticky_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && tick_1hz |=> stat_q[resi_pkg::B_TICK])
      else $error("tick flag not set");

   clear_works_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && wr_clr && wdata[resi_pkg::B_TICK] && !tick_1hz |=> !stat_q[resi_pkg::B_TICK])
      else $error("tick flag not cleared");

   flag_holds_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && stat_q[resi_pkg::B_CLOCK_EV] && !wr_clr |=> stat_q[resi_pkg::B_CLOCK_EV])
      else $error("clock event flag dropped");

   corrupt_set_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && counters_bad |=> stat_q[resi_pkg::B_CORRUPT])
      else $error("corruption flag not set");

   mask_on_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && wr_ien |=> (mask_q & $past(wdata[N-1:0])) == $past(wdata[N-1:0]))
      else $error("enable write lost");

   mask_off_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && wr_idis |=> (mask_q & $past(wdata[N-1:0])) == '0)
      else $error("disable write lost");

   irq_follow_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && $past(ce) ##1 ce |-> irq == $past(|(stat_q & mask_q)))
      else $error("interrupt does not follow flags");

   alarm_rise_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && match_now && !match_prev_q |=> stat_q[resi_pkg::B_MATCH])
      else $error("alarm flag not set");

   grant_set_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && updating |=> stat_q[resi_pkg::B_GRANT])
      else $error("grant flag not set");

   read_once_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && rd && addr == resi_pkg::ADR_IRQ_MASK_VIEW ##1 ce && !rd |=> rdata == resi_pkg::RST_WORD)
      else $error("read data held too long");

   clock_event_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && clock_sel_evt |=> stat_q[resi_pkg::B_CLOCK_EV])
      else $error("clock event flag not set");

   date_event_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && date_sel_evt |=> stat_q[resi_pkg::B_DATE_EV])
      else $error("date event flag not set");

   mask_keep_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && !wr_ien && !wr_idis |=> mask_q == $past(mask_q))
      else $error("mask changed without write");

   alarm_keep_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && !wr_clk_alm |=> bad_q[resi_pkg::B_BAD_CLOCK_ALM] == $past(bad_q[resi_pkg::B_BAD_CLOCK_ALM]))
      else $error("alarm validity changed");

endmodule

// [resi_pkg.sv]
// Shared constants of the clock event status and interrupt block
package resi_pkg;

   // ************************************************
   // Register byte addresses
   // ************************************************
   localparam logic [31:0] ADR_CONTROL_WORD = 32'h400E_1460;
   localparam logic [31:0] ADR_CLOCK_ENTRY = 32'h400E_1468;
   localparam logic [31:0] ADR_DATE_ENTRY = 32'h400E_146C;
   localparam logic [31:0] ADR_CLOCK_ALARM = 32'h400E_1470;
   localparam logic [31:0] ADR_DATE_ALARM = 32'h400E_1474;
   localparam logic [31:0] ADR_EVENT_STATUS = 32'h400E_1478;
   localparam logic [31:0] ADR_STATUS_CLEAR_COMMAND = 32'h400E_147C;
   localparam logic [31:0] ADR_IRQ_ENABLE_SET = 32'h400E_1480;
   localparam logic [31:0] ADR_IRQ_ENABLE_CLEAR = 32'h400E_1484;
   localparam logic [31:0] ADR_IRQ_MASK_VIEW = 32'h400E_1488;
   localparam logic [31:0] ADR_ENTRY_VALIDITY = 32'h400E_148C;

   // ************************************************
   // Status, mask and validity bit positions
   // ************************************************
   localparam int NUM_SRC = 6;
   localparam int B_GRANT = 0;
   localparam int B_MATCH = 1;
   localparam int B_TICK = 2;
   localparam int B_CLOCK_EV = 3;
   localparam int B_DATE_EV = 4;
   localparam int B_CORRUPT = 5;
   localparam int B_BAD_CLOCK = 0;
   localparam int B_BAD_DATE = 1;
   localparam int B_BAD_CLOCK_ALM = 2;
   localparam int B_BAD_DATE_ALM = 3;

   // ************************************************
   // Field positions of the clock, date and alarm words
   // ************************************************
   localparam int F_SEC = 0;
   localparam int F_MIN = 8;
   localparam int F_HOUR = 16;
   localparam int F_AMPM = 22;
   localparam int F_CENT = 0;
   localparam int F_YEAR = 8;
   localparam int F_MONTH = 16;
   localparam int F_DAY = 21;
   localparam int F_DATE = 24;
   localparam int E_SEC = 7;
   localparam int E_MIN = 15;
   localparam int E_HOUR = 23;
   localparam int E_MONTH = 23;
   localparam int E_DATE = 31;
   localparam int F_CLK_SEL = 8;
   localparam int F_DATE_SEL = 16;

   // ************************************************
   // Event selector codes
   // ************************************************
   localparam logic [1:0] SEL_MINUTE = 2'h0;
   localparam logic [1:0] SEL_HOUR = 2'h1;
   localparam logic [1:0] SEL_MIDNIGHT = 2'h2;
   localparam logic [1:0] SEL_NOON = 2'h3;
   localparam logic [1:0] SEL_WEEK = 2'h0;
   localparam logic [1:0] SEL_MONTH = 2'h1;
   localparam logic [1:0] SEL_YEAR = 2'h2;

   // ************************************************
   // Legal BCD ranges and reset values
   // ************************************************
   localparam logic [7:0] BCD_ZERO = 8'h00;
   localparam logic [7:0] BCD_ONE = 8'h01;
   localparam logic [7:0] BCD_MAX_MS = 8'h59;
   localparam logic [7:0] BCD_MAX_H12 = 8'h12;
   localparam logic [7:0] BCD_MAX_H24 = 8'h23;
   localparam logic [7:0] BCD_MIN_CENT = 8'h19;
   localparam logic [7:0] BCD_MAX_CENT = 8'h20;
   localparam logic [7:0] BCD_MAX_YEAR = 8'h99;
   localparam logic [7:0] BCD_MAX_MONTH = 8'h12;
   localparam logic [7:0] BCD_MAX_DAY = 8'h07;
   localparam logic [7:0] BCD_MAX_DATE = 8'h31;
   localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

// [tb_resi_status_irq.sv]
// Self-checking testbench of the clock event status and interrupt block
`timescale 1ns/100ps
module tb;
   logic clk;
   logic rstn;
   logic ce;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic [31:0] rdata;
   logic [31:0] cur_clock;
   logic [31:0] cur_date;
   logic mode_12h;
   logic updating;
   logic [7:0] ev; // tick, minute, hour, noon, midnight, week, month, year
   logic irq;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   localparam logic [31:0] GOOD_CLOCK = 32'h0012_3000;
   localparam logic [31:0] GOOD_DATE = 32'h1565_2420;

   resi_status_irq dut_u (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .cur_clock(cur_clock), .cur_date(cur_date), .mode_12h(mode_12h), .updating(updating),
      .tick_1hz(ev[0]), .minute_roll(ev[1]), .hour_roll(ev[2]), .noon_evt(ev[3]), .midnight_evt(ev[4]),
      .week_roll(ev[5]), .month_roll(ev[6]), .year_roll(ev[7]), .irq(irq));

   // ************************************************
   // Clock, timeout and shared tasks
   // ************************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 4000) begin
         n_errors++;
         $display("CHECK FAILED at %0t ns: run hung", $time);
         test_done();
      end
   end

   task automatic test_done();
      $display("Errors: %0d, checks: %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t ns: %s got %h want %h", $time, msg, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the taking edge
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string msg);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp, msg);
   endtask

   task automatic pulse(input logic [7:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 8'h00;
   endtask

   // Interrupt is registered, so give it two edges to follow
   task automatic irq_chk(input logic exp, input string msg);
      repeat (2) @(posedge clk);
      #1;
      chk({31'h0, irq}, {31'h0, exp}, msg);
   endtask

   task automatic set_clock(input logic [31:0] v);
      @(posedge clk);
      cur_clock <= v;
   endtask

   // ************************************************
   // Scenarios
   // ************************************************
   task automatic t_reset();
      rd_chk(resi_pkg::ADR_EVENT_STATUS, 32'h0, "status after reset");
      @(posedge clk);
      #1;
      chk(rdata, 32'h0, "read data returns to zero");
      rd_chk(resi_pkg::ADR_IRQ_MASK_VIEW, 32'h0, "mask after reset");
      rd_chk(resi_pkg::ADR_ENTRY_VALIDITY, 32'h0, "validity after reset");
      rd_chk(resi_pkg::ADR_IRQ_ENABLE_SET, 32'h0, "write-only reads zero");
      rd_chk(32'h400E_1500, 32'h0, "unmapped reads zero");
      irq_chk(1'b0, "irq after reset");
   endtask

   // Clock enable low: an event taken then must leave no trace
   task automatic t_freeze();
      @(posedge clk);
      ce <= 1'b0;
      pulse(8'h01);
      @(posedge clk);
      ce <= 1'b1;
      rd_chk(resi_pkg::ADR_EVENT_STATUS, 32'h0, "frozen tick ignored");
   endtask

   task automatic t_tick();
      pulse(8'h01);
      pulse(8'h01);
      rd_chk(resi_pkg::ADR_EVENT_STATUS, 32'h1 << resi_pkg::B_TICK, "tick sticky");
      wr_reg(resi_pkg::ADR_STATUS_CLEAR_COMMAND, 32'h0);
      rd_chk(resi_pkg::ADR_EVENT_STATUS, 32'h1 << resi_pkg::B_TICK, "zero clear no effect");
      wr_reg(resi_pkg::ADR_STATUS_CLEAR_COMMAND, 32'h1 << resi_pkg::B_TICK);
      rd_chk(resi_pkg::ADR_EVENT_STATUS, 32'h0, "tick cleared");
   endtask

   task automatic t_mask();
      wr_reg(resi_pkg::ADR_IRQ_ENABLE_SET, 32'h0000_003F);
      rd_chk(resi_pkg::ADR_IRQ_MASK_VIEW, 32'h0000_003F, "all enabled");
      wr_reg(resi_pkg::ADR_IRQ_ENABLE_CLEAR, 32'h0000_0015);
      rd_chk(resi_pkg::ADR_IRQ_MASK_VIEW, 32'h0000_002A, "some disabled");
      wr_reg(resi_pkg::ADR_IRQ_ENABLE_CLEAR, 32'h0);
      wr_reg(resi_pkg::ADR_IRQ_ENABLE_SET, 32'h0);
      rd_chk(resi_pkg::ADR_IRQ_MASK_VIEW, 32'h0000_002A, "zero writes keep mask");
      pulse(8'h01);
      irq_chk(1'b0, "masked tick no irq");
      wr_reg(resi_pkg::ADR_IRQ_ENABLE_SET, 32'h1 << resi_pkg::B_TICK);
      irq_chk(1'b1, "unmasked tick irq");
      wr_reg(resi_pkg::ADR_STATUS_CLEAR_COMMAND, 32'h1 << resi_pkg::B_TICK);
      irq_chk(1'b0, "irq drops on clear");
   endtask

   // One selector setting: the wrong event must not set, the right one must
   task automatic ev_case(input logic [31:0] ctrl, input logic [7:0] bad, input logic [7:0] hit, input int b);
      wr_reg(resi_pkg::ADR_CONTROL_WORD, ctrl);
      pulse(bad);
      rd_chk(resi_pkg::ADR_EVENT_STATUS, 32'h0, "unselected event");
      pulse(hit);
      rd_chk(resi_pkg::ADR_EVENT_STATUS, 32'h1 << b, "selected event held");
      wr_reg(resi_pkg::ADR_STATUS_CLEAR_COMMAND, 32'h1 << b);
   endtask

   task automatic t_select();
      logic [1:0] cs [4] = '{resi_pkg::SEL_MINUTE, resi_pkg::SEL_HOUR, resi_pkg::SEL_NOON, resi_pkg::SEL_MIDNIGHT};
      logic [7:0] ch [4] = '{8'h02, 8'h04, 8'h08, 8'h10};
      logic [1:0] ds [3] = '{resi_pkg::SEL_WEEK, resi_pkg::SEL_MONTH, resi_pkg::SEL_YEAR};
      logic [7:0] dh [3] = '{8'h20, 8'h40, 8'h80};
      for (int i = 0; i < 4; i++) begin
         ev_case(32'(cs[i]) << resi_pkg::F_CLK_SEL, ch[(i + 1) % 4], ch[i], resi_pkg::B_CLOCK_EV);
      end
      for (int i = 0; i < 3; i++) begin
         ev_case(32'(ds[i]) << resi_pkg::F_DATE_SEL, dh[(i + 1) % 3], dh[i], resi_pkg::B_DATE_EV);
      end
   endtask

   task automatic t_alarm();
      wr_reg(resi_pkg::ADR_CLOCK_ALARM, 32'h0000_C5B0);
      set_clock(32'h0012_3030);
      rd_chk(resi_pkg::ADR_EVENT_STATUS, 32'h0, "enabled minute blocks");
      set_clock(32'h0012_4530);
      rd_chk(resi_pkg::ADR_EVENT_STATUS, 32'h1 << resi_pkg::B_MATCH, "alarm match");
      wr_reg(resi_pkg::ADR_STATUS_CLEAR_COMMAND, 32'h1 << resi_pkg::B_MATCH);
      set_clock(GOOD_CLOCK);
      wr_reg(resi_pkg::ADR_CLOCK_ALARM, 32'h0000_45B0);
      set_clock(32'h0012_3030);
      rd_chk(resi_pkg::ADR_EVENT_STATUS, 32'h1 << resi_pkg::B_MATCH, "disabled minute ignored");
      wr_reg(resi_pkg::ADR_CLOCK_ALARM, 32'h0);
      wr_reg(resi_pkg::ADR_STATUS_CLEAR_COMMAND, 32'h1 << resi_pkg::B_MATCH);
      set_clock(GOOD_CLOCK);
      wr_reg(resi_pkg::ADR_DATE_ALARM, 32'h9585_0000);
      rd_chk(resi_pkg::ADR_EVENT_STATUS, 32'h1 << resi_pkg::B_MATCH, "date alarm match");
      wr_reg(resi_pkg::ADR_DATE_ALARM, 32'h0101_0000);
      wr_reg(resi_pkg::ADR_STATUS_CLEAR_COMMAND, 32'h1 << resi_pkg::B_MATCH);
   endtask

   task automatic t_corrupt();
      set_clock(32'h0012_305A);
      wr_reg(resi_pkg::ADR_STATUS_CLEAR_COMMAND, 32'h1 << resi_pkg::B_CORRUPT);
      rd_chk(resi_pkg::ADR_EVENT_STATUS, 32'h1 << resi_pkg::B_CORRUPT, "held while invalid");
      irq_chk(1'b1, "corruption irq");
      set_clock(GOOD_CLOCK);
      @(posedge clk);
      cur_date <= 32'h1573_2420;
      @(posedge clk);
      cur_date <= GOOD_DATE;
      wr_reg(resi_pkg::ADR_STATUS_CLEAR_COMMAND, 32'h1 << resi_pkg::B_CORRUPT);
      rd_chk(resi_pkg::ADR_EVENT_STATUS, 32'h0, "valid since clear");
   endtask

   task automatic t_grant();
      @(posedge clk);
      updating <= 1'b1;
      wr_reg(resi_pkg::ADR_STATUS_CLEAR_COMMAND, 32'h1 << resi_pkg::B_GRANT);
      rd_chk(resi_pkg::ADR_EVENT_STATUS, 32'h1 << resi_pkg::B_GRANT, "grant while stopped");
      irq_chk(1'b0, "grant masked");
      @(posedge clk);
      updating <= 1'b0;
      wr_reg(resi_pkg::ADR_STATUS_CLEAR_COMMAND, 32'h1 << resi_pkg::B_GRANT);
      rd_chk(resi_pkg::ADR_EVENT_STATUS, 32'h0, "grant low free running");
   endtask

   task automatic t_validity();
      logic [31:0] adr [4] = '{resi_pkg::ADR_CLOCK_ENTRY, resi_pkg::ADR_DATE_ENTRY, resi_pkg::ADR_CLOCK_ALARM,
         resi_pkg::ADR_DATE_ALARM};
      logic [31:0] bad [4] = '{32'h0000_001A, 32'h1573_2420, 32'h0024_0000, 32'h3201_0000};
      logic [31:0] good [4] = '{GOOD_CLOCK, GOOD_DATE, 32'h0, 32'h0101_0000};
      for (int i = 0; i < 4; i++) begin
         wr_reg(adr[i], bad[i]);
         rd_chk(resi_pkg::ADR_ENTRY_VALIDITY, 32'h1 << i, "bad entry flagged");
         wr_reg(adr[i], good[i]);
         rd_chk(resi_pkg::ADR_ENTRY_VALIDITY, 32'h0, "reprogrammed clears");
      end
      @(posedge clk);
      mode_12h <= 1'b1;
      wr_reg(resi_pkg::ADR_CLOCK_ENTRY, 32'h0000_3000);
      rd_chk(resi_pkg::ADR_ENTRY_VALIDITY, 32'h1, "hour zero in 12h");
      wr_reg(resi_pkg::ADR_CLOCK_ENTRY, GOOD_CLOCK);
      rd_chk(resi_pkg::ADR_ENTRY_VALIDITY, 32'h0, "hour twelve in 12h");
      @(posedge clk);
      mode_12h <= 1'b0;
   endtask

   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      addr = 32'h0;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      ev = 8'h00;
      cur_clock = GOOD_CLOCK;
      cur_date = GOOD_DATE;
      mode_12h = 1'b0;
      updating = 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_freeze();
      t_tick();
      t_mask();
      t_select();
      t_alarm();
      t_corrupt();
      t_grant();
      t_validity();
      test_done();
   end
endmodule
